//--- rtl/async_serial_comm_interface.sv
// Operation
// R1: bit time is eight ticks of divisor+1 clocks
// R2: divisor built from high and low bytes
// R3: one start bit, one to eight data
// R4: optional parity, even or odd
// R5: one or two stop bits
// R6: parity, overrun, framing, break flags kept
// R7: receive error flag ORs all four errors
// R8: transmit ready while buffer accepts character
// R9: transmit empty when shifter has nothing left
// R10: receive ready while character waits
// R11: separate interrupt enables; break always interrupts
// R12: idle-line and address-bit wake-up modes
// R13: transmitter and receiver enabled independently
// R14: buffer before tx shifter, after rx shifter
// R15: data in low byte, high byte zero
// R16: master uses sixteen-bit accesses only
// R17: optional sixteen-level fifos for both directions
// R18: lsb first, line idles high
`timescale 1ns/1ns
`default_nettype none
module sci_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   localparam int AW = $clog2(DEPTH),
   localparam int CW = $clog2(DEPTH + 1)
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic flush,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData,
   output logic [CW-1:0] count
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic push;
   logic pop;
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : badDepth
      $error("fifo depth must be a power of two");
   end
   assign inReady = count != CW'(DEPTH);
   assign outValid = count != '0;
   assign outData = mem[rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem[wrPtr] <= inData;
      end
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end
      else if (flush)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end
      else
      begin
         wrPtr <= wrPtr + AW'(push);
         rdPtr <= rdPtr + AW'(pop);
         count <= count + CW'(push) - CW'(pop);
      end
   end
endmodule // sci_fifo

module async_serial_comm_interface
   import sci_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [15:0] addr,
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic [15:0] wrData,
   output logic [15:0] rdData,
   input wire logic serialRxPin,
   output logic serialTxPin,
   output logic txIrq,
   output logic rxIrq
);
   localparam int CW = $clog2(FIFO_DEPTH + 1);
   if (FIFO_DEPTH > 16)
   begin : badLevel
      $error("fifo level field holds at most sixteen");
   end

   function automatic logic parityOf(logic [7:0] d, logic [2:0] len, logic even);
      logic [7:0] m;
      m = 8'hFF >> (3'h7 - len);
      return (^(d & m)) ^ !even;
   endfunction

   // ********************************
   // register file
   // ********************************
   format_t fmt;
   logic [7:0] ctl1;
   logic [7:0] baudHi;
   logic [7:0] baudLo;
   logic [1:0] intEn;
   logic fifoEn;
   logic [7:0] fifoCt;
   logic [7:0] prio;
   logic wrFormat;
   logic txLoad;
   logic softReset;
   logic txFlush;
   logic rxFlush;
   logic rxBufRead;

   assign softReset = ctl1[CTL1_SW_RESET];
   // high byte of wrData is never looked at
   assign txFlush = softReset || (wrEn && addr == ADDR_FIFO_TX && wrData[FIFO_FLUSH]); // see R15
   assign rxFlush = softReset || (wrEn && addr == ADDR_FIFO_RX && wrData[FIFO_FLUSH]);
   assign rxBufRead = rdEn && addr == ADDR_RX_BUF;
   assign wrFormat = wrEn && addr == ADDR_FORMAT;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         fmt <= format_t'(RESET_FORMAT);
         baudHi <= RESET_ZERO;
         baudLo <= RESET_ZERO;
         intEn <= 2'h0;
         fifoEn <= 1'b0;
         fifoCt <= RESET_ZERO;
         prio <= RESET_ZERO;
      end
      else if (wrEn)
      begin
         unique case (addr)
            ADDR_FORMAT: fmt <= format_t'(wrData[7:0]); // see R3
            ADDR_BAUD_HI: baudHi <= wrData[7:0]; // see R2
            ADDR_BAUD_LO: baudLo <= wrData[7:0]; // see R2
            ADDR_CTRL2: intEn <= wrData[1:0]; // see R11
            ADDR_FIFO_TX: fifoEn <= wrData[FIFO_EN]; // see R17
            ADDR_FIFO_CT: fifoCt <= wrData[7:0];
            ADDR_PRIORITY: prio <= wrData[7:0];
            default: ;
         endcase
      end
   end

   // wake bit is consumed by the frame that carries it
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ctl1 <= RESET_ZERO;
      end
      else if (wrEn && addr == ADDR_CTRL1)
      begin
         ctl1 <= wrData[7:0];
      end
      else if (txLoad)
      begin
         ctl1[CTL1_TX_WAKE] <= 1'b0;
      end
   end

   // ********************************
   // baud tick
   // ********************************
   logic [15:0] divisor;
   logic [15:0] baudCnt;
   logic tick;
   assign divisor = {baudHi, baudLo}; // see R2
   // zero divisor behaves as one: sixteen clocks per bit
   assign tick = baudCnt >= ((divisor == 16'h0000) ? 16'h0001 : divisor); // see R1
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         baudCnt <= 16'h0000;
      end
      else
      begin
         baudCnt <= tick ? 16'h0000 : baudCnt + 16'h0001;
      end
   end

   // ********************************
   // transmit path
   // ********************************
   logic txCanPush;
   logic txOutValid;
   logic [7:0] txOutData;
   logic [CW-1:0] txCount;
   logic txInReady;
   serial_state_t txState;
   logic [2:0] txPhase;
   logic [2:0] txIdx;
   logic [7:0] txShift;
   logic txAddrBit;
   logic txPar;
   logic txSecondStop;

   // without fifo mode the queue acts as a single buffer register
   assign txCanPush = txInReady && (fifoEn || txCount == '0); // see R14
   assign txLoad = tick && txState == S_IDLE && txOutValid && ctl1[CTL1_TX_EN]; // see R13

   sci_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) txFifo (
      .clock(clock),
      .rst(rst),
      .flush(txFlush),
      .inValid(wrEn && addr == ADDR_TX_BUF && txCanPush),
      .inReady(txInReady),
      .inData(wrData[7:0]),
      .outValid(txOutValid),
      .outReady(txLoad),
      .outData(txOutData),
      .count(txCount)
   ); // see R17

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         txState <= S_IDLE;
         txPhase <= 3'h0;
         txIdx <= 3'h0;
         txShift <= 8'h00;
         txAddrBit <= 1'b0;
         txPar <= 1'b0;
         txSecondStop <= 1'b0;
         serialTxPin <= 1'b1;
      end
      else if (softReset)
      begin
         txState <= S_IDLE;
         txPhase <= 3'h0;
         serialTxPin <= 1'b1; // see R18
      end
      else if (txLoad)
      begin
         txShift <= txOutData;
         txAddrBit <= ctl1[CTL1_TX_WAKE]; // see R12
         txPar <= parityOf(txOutData, fmt.lenMinus1, fmt.evenParity); // see R4
         txPhase <= 3'h0;
         txState <= S_START;
         serialTxPin <= 1'b0; // see R3
      end
      else if (tick && txState != S_IDLE)
      begin
         txPhase <= txPhase + 3'h1; // see R1
         if (txPhase == LAST_TICK)
         begin
            unique case (txState)
               S_START:
               begin
                  serialTxPin <= txShift[0]; // see R18
                  txShift <= txShift >> 1;
                  txIdx <= 3'h0;
                  txState <= S_DATA;
               end
               S_DATA:
               begin
                  if (txIdx != fmt.lenMinus1)
                  begin
                     serialTxPin <= txShift[0];
                     txShift <= txShift >> 1;
                     txIdx <= txIdx + 3'h1;
                  end
                  else if (fmt.multiEn && fmt.addrMode)
                  begin
                     serialTxPin <= txAddrBit; // see R12
                     txState <= S_ADDR;
                  end
                  else if (fmt.parityEn)
                  begin
                     serialTxPin <= txPar;
                     txState <= S_PARITY;
                  end
                  else
                  begin
                     serialTxPin <= 1'b1;
                     txSecondStop <= 1'b0;
                     txState <= S_STOP;
                  end
               end
               S_ADDR:
               begin
                  serialTxPin <= fmt.parityEn ? txPar : 1'b1; // see R4
                  txSecondStop <= 1'b0;
                  txState <= fmt.parityEn ? S_PARITY : S_STOP;
               end
               S_PARITY:
               begin
                  serialTxPin <= 1'b1;
                  txSecondStop <= 1'b0;
                  txState <= S_STOP;
               end
               S_STOP:
               begin
                  if (fmt.twoStop && !txSecondStop)
                  begin
                     txSecondStop <= 1'b1; // see R5
                  end
                  else
                  begin
                     txState <= S_IDLE;
                  end
               end
               default: txState <= S_IDLE;
            endcase
         end
      end
   end

   // ********************************
   // receive shifter
   // ********************************
   serial_state_t rxState;
   logic [2:0] rxPhase;
   logic [2:0] rxIdx;
   logic [7:0] rxShift;
   logic rxAddrBit;
   logic rxParBit;
   logic rxSecondStop;
   logic [6:0] idleCnt;
   logic frameIdle;
   logic frameDone;
   logic frameFraming;
   logic [7:0] frameData;
   logic frameParErr;
   logic frameWake;
   logic rxStopLow;
   logic [7:0] rxAligned;

   assign rxAligned = rxShift >> (3'h7 - fmt.lenMinus1); // see R18
   assign rxStopLow = !serialRxPin;

   // idle-line detector: ten quiet bit times arm the wake condition
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         idleCnt <= 7'h00;
      end
      else if (rxState != S_IDLE || !serialRxPin)
      begin
         idleCnt <= 7'h00;
      end
      else if (tick && idleCnt != IDLE_TICKS)
      begin
         idleCnt <= idleCnt + 7'h01; // see R12
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rxState <= S_IDLE;
         rxPhase <= 3'h0;
         rxIdx <= 3'h0;
         rxShift <= 8'h00;
         rxAddrBit <= 1'b0;
         rxParBit <= 1'b0;
         rxSecondStop <= 1'b0;
         frameIdle <= 1'b0;
         frameDone <= 1'b0;
         frameFraming <= 1'b0;
      end
      else if (softReset || !ctl1[CTL1_RX_EN]) // see R13
      begin
         rxState <= S_IDLE;
         rxPhase <= 3'h0;
         frameDone <= 1'b0;
      end
      else
      begin
         frameDone <= 1'b0;
         if (tick)
         begin
            rxPhase <= rxPhase + 3'h1;
            unique case (rxState)
               S_IDLE:
               begin
                  rxPhase <= 3'h0;
                  if (!serialRxPin)
                  begin
                     frameIdle <= idleCnt == IDLE_TICKS;
                     rxState <= S_START;
                  end
               end
               S_START:
               begin
                  // a glitch shorter than half a bit is dropped
                  if (serialRxPin)
                  begin
                     rxState <= S_IDLE;
                  end
                  else if (rxPhase == MID_TICK)
                  begin
                     rxPhase <= 3'h0;
                     rxIdx <= 3'h0;
                     rxShift <= 8'h00;
                     rxState <= S_DATA; // see R3
                  end
               end
               default:
               begin
                  if (rxPhase == LAST_TICK)
                  begin
                     unique case (rxState)
                        S_DATA:
                        begin
                           rxShift <= {serialRxPin, rxShift[7:1]}; // see R18
                           rxIdx <= rxIdx + 3'h1;
                           rxSecondStop <= 1'b0;
                           if (rxIdx == fmt.lenMinus1)
                           begin
                              rxState <= (fmt.multiEn && fmt.addrMode) ? S_ADDR :
                                 fmt.parityEn ? S_PARITY : S_STOP;
                           end
                        end
                        S_ADDR:
                        begin
                           rxAddrBit <= serialRxPin; // see R12
                           rxState <= fmt.parityEn ? S_PARITY : S_STOP;
                        end
                        S_PARITY:
                        begin
                           rxParBit <= serialRxPin; // see R4
                           rxState <= S_STOP;
                        end
                        default:
                        begin
                           frameFraming <= rxSecondStop ? (frameFraming || rxStopLow) : rxStopLow;
                           if (fmt.twoStop && !rxSecondStop)
                           begin
                              rxSecondStop <= 1'b1; // see R5
                           end
                           else
                           begin
                              frameDone <= 1'b1;
                              rxState <= S_IDLE;
                           end
                        end
                     endcase
                  end
               end
            endcase
         end
      end
   end

   // frameFraming above already holds the last stop sample when frameDone rises
   assign frameData = rxAligned;
   assign frameParErr = fmt.parityEn && rxParBit != parityOf(rxAligned, fmt.lenMinus1, fmt.evenParity);
   assign frameWake = fmt.addrMode ? rxAddrBit : frameIdle;

   // ********************************
   // receive buffer and flags
   // ********************************
   logic rxInReady;
   logic rxCanPush;
   logic rxAccept;
   logic rxOutValid;
   logic [7:0] rxOutData;
   logic [CW-1:0] rxCount;
   rx_status_t rxStat;
   logic flagParity;
   logic flagOverrun;
   logic flagFraming;
   logic flagBreak;
   logic flagWake;
   logic txReady;
   logic txEmpty;

   assign rxCanPush = rxInReady && (fifoEn || rxCount == '0); // see R14
   // sleeping receiver keeps only frames that carry the wake condition
   assign rxAccept = frameDone && (!(fmt.multiEn && ctl1[CTL1_SLEEP]) || frameWake); // see R12

   sci_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rxFifo (
      .clock(clock),
      .rst(rst),
      .flush(rxFlush),
      .inValid(rxAccept && rxCanPush),
      .inReady(rxInReady),
      .inData(frameData),
      .outValid(rxOutValid),
      .outReady(rxBufRead),
      .outData(rxOutData),
      .count(rxCount)
   ); // see R17

   // new events beat the clear in the same cycle
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         flagParity <= 1'b0;
         flagOverrun <= 1'b0;
         flagFraming <= 1'b0;
         flagBreak <= 1'b0;
         flagWake <= 1'b0;
      end
      else
      begin
         flagParity <= (flagParity && !rxBufRead && !softReset) || (rxAccept && frameParErr); // see R6
         flagFraming <= (flagFraming && !rxBufRead && !softReset) || (frameDone && frameFraming); // see R6
         flagOverrun <= (flagOverrun && !softReset) || (rxAccept && !rxCanPush); // see R6
         flagBreak <= (flagBreak && !softReset) || (frameDone && frameFraming &&
            frameData == 8'h00 && !(fmt.parityEn && rxParBit)); // see R6
         flagWake <= (flagWake && !rxBufRead && !softReset) || (rxAccept && fmt.multiEn && frameWake);
      end
   end

   assign txReady = txCanPush; // see R8
   assign txEmpty = txState == S_IDLE && txCount == '0; // see R9
   always_comb
   begin
      rxStat = '0;
      rxStat.rxError = flagParity || flagOverrun || flagFraming || flagBreak; // see R7
      rxStat.rxReady = rxOutValid; // see R10
      rxStat.breakDet = flagBreak;
      rxStat.framing = flagFraming;
      rxStat.overrun = flagOverrun;
      rxStat.parity = flagParity;
      rxStat.wake = flagWake;
   end

   // ********************************
   // read port and interrupts
   // ********************************
   logic [7:0] readByte;
   always_comb
   begin
      unique case (addr)
         ADDR_FORMAT: readByte = fmt;
         ADDR_CTRL1: readByte = ctl1;
         ADDR_BAUD_HI: readByte = baudHi;
         ADDR_BAUD_LO: readByte = baudLo;
         ADDR_CTRL2: readByte = {txReady, txEmpty, 4'h0, intEn};
         ADDR_RX_STATUS: readByte = rxStat;
         ADDR_RX_EMU: readByte = rxOutData;
         ADDR_RX_BUF: readByte = rxOutData;
         ADDR_FIFO_TX: readByte = {fifoEn, 2'h0, 5'(txCount)};
         ADDR_FIFO_RX: readByte = {3'h0, 5'(rxCount)};
         ADDR_FIFO_CT: readByte = fifoCt;
         ADDR_PRIORITY: readByte = prio;
         default: readByte = 8'h00;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rdData <= 16'h0000;
         txIrq <= 1'b0;
         rxIrq <= 1'b0;
      end
      else
      begin
         if (rdEn)
         begin
            rdData <= {8'h00, readByte}; // see R15
         end
         txIrq <= intEn[CTL2_TX_INT] && txReady; // see R11
         rxIrq <= (intEn[CTL2_RX_INT] && (rxOutValid || rxStat.rxError)) || flagBreak; // see R11
      end
   end
endmodule // async_serial_comm_interface
`default_nettype wire

//--- rtl/sci_pkg.sv
`default_nettype none
package sci_pkg;
   // ********************************
   // register addresses
   // ********************************
   localparam logic [15:0] ADDR_FORMAT = 16'h7050;
   localparam logic [15:0] ADDR_CTRL1 = 16'h7051;
   localparam logic [15:0] ADDR_BAUD_HI = 16'h7052;
   localparam logic [15:0] ADDR_BAUD_LO = 16'h7053;
   localparam logic [15:0] ADDR_CTRL2 = 16'h7054;
   localparam logic [15:0] ADDR_RX_STATUS = 16'h7055;
   localparam logic [15:0] ADDR_RX_EMU = 16'h7056;
   localparam logic [15:0] ADDR_RX_BUF = 16'h7057;
   localparam logic [15:0] ADDR_TX_BUF = 16'h7059;
   localparam logic [15:0] ADDR_FIFO_TX = 16'h705A;
   localparam logic [15:0] ADDR_FIFO_RX = 16'h705B;
   localparam logic [15:0] ADDR_FIFO_CT = 16'h705C;
   localparam logic [15:0] ADDR_PRIORITY = 16'h705F;
   // ********************************
   // field positions and resets
   // ********************************
   localparam int CTL1_RX_EN = 0;
   localparam int CTL1_TX_EN = 1;
   localparam int CTL1_SLEEP = 2;
   localparam int CTL1_TX_WAKE = 3;
   localparam int CTL1_SW_RESET = 5;
   localparam int CTL2_TX_INT = 0;
   localparam int CTL2_RX_INT = 1;
   localparam int FIFO_EN = 7;
   localparam int FIFO_FLUSH = 6;
   localparam logic [7:0] RESET_FORMAT = 8'h07;
   localparam logic [7:0] RESET_ZERO = 8'h00;
   // ********************************
   // timing
   // ********************************
   localparam logic [2:0] LAST_TICK = 3'h7;
   localparam logic [2:0] MID_TICK = 3'h3;
   localparam logic [6:0] IDLE_TICKS = 7'h50;
   // ********************************
   // types
   // ********************************
   typedef struct packed {
      logic twoStop;
      logic evenParity;
      logic parityEn;
      logic multiEn;
      logic addrMode;
      logic [2:0] lenMinus1;
   } format_t;
   typedef struct packed {
      logic rxError;
      logic rxReady;
      logic breakDet;
      logic framing;
      logic overrun;
      logic parity;
      logic wake;
      logic zero;
   } rx_status_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_START = 3'h1,
      S_DATA = 3'h3,
      S_ADDR = 3'h2,
      S_PARITY = 3'h6,
      S_STOP = 3'h7
   } serial_state_t;
endpackage
`default_nettype wire

//--- verif/serial_comm_checker_sva.sv
`timescale 1ns/1ns
`default_nettype none
module serial_comm_checker
   import sci_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [15:0] addr,
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic [15:0] wrData,
   input wire logic [15:0] rdData,
   input wire logic serialRxPin,
   input wire logic serialTxPin,
   input wire logic txIrq,
   input wire logic rxIrq
);
   // ****
   // shadows
   // ****
   logic [7:0] fmt, divHi, divLo;
   logic txIe, prevTx;
   int runLen, bitLen;
   always_comb
      bitLen = {divHi, divLo} == 16'h0000 ? 16 : 8 * (int'({divHi, divLo}) + 1);
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         fmt <= RESET_FORMAT;
         divHi <= 8'h00;
         divLo <= 8'h00;
         txIe <= 1'b0;
      end
      else if (wrEn)
      begin
         if (addr == ADDR_FORMAT) fmt <= wrData[7:0];
         if (addr == ADDR_BAUD_HI) divHi <= wrData[7:0];
         if (addr == ADDR_BAUD_LO) divLo <= wrData[7:0];
         if (addr == ADDR_CTRL2) txIe <= wrData[CTL2_TX_INT];
      end
   // run length instead of long repetition, which would not unroll
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         prevTx <= 1'b1;
         runLen <= 1;
      end
      else
      begin
         prevTx <= serialTxPin;
         runLen <= serialTxPin != prevTx ? 1 : runLen + 1;
      end
   // ****
   // checks
   // ****
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   a_upper_zero: assert property (rdData[15:8] == 8'h00)
      else $error("upper read byte set");
   a_unmapped_zero: assert property (rdEn && addr == 16'h7058 |=> rdData == 16'h0000)
      else $error("unmapped read not zero");
   a_read_holds: assert property (!rdEn |=> $stable(rdData))
      else $error("read data moved");
   a_format_back: assert property (rdEn && addr == ADDR_FORMAT |=> rdData[7:0] == $past(fmt))
      else $error("format readback");
   a_divisor_back: assert property (rdEn && addr == ADDR_BAUD_LO |=> rdData[7:0] == $past(divLo))
      else $error("divisor readback");
   a_tx_idle_high: assert property ($fell(rst) |-> serialTxPin)
      else $error("tx line low after reset");
   a_low_run_whole: assert property (!prevTx && serialTxPin |-> runLen % bitLen == 0)
      else $error("low run not whole bits");
   a_tx_irq_gated: assert property (!txIe && !$past(txIe) |-> !txIrq)
      else $error("tx irq while disabled");
endmodule // serial_comm_checker
bind async_serial_comm_interface serial_comm_checker u_chk (.clock(clock), .rst(rst),
   .addr(addr), .wrEn(wrEn), .rdEn(rdEn), .wrData(wrData), .rdData(rdData),
   .serialRxPin(serialRxPin), .serialTxPin(serialTxPin), .txIrq(txIrq), .rxIrq(rxIrq));
`default_nettype wire

//--- verif/serial_peer.sv
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
   input wire logic clock,
   input wire logic dutTx,
   output logic dutRx,
   output logic rxValid,
   output logic [7:0] rxByte
);
   int bitLen = 16;
   // ****
   // frames toward the device
   // ****
   task automatic sendFrame(input logic [8:0] bits, input int nBits, input logic stopBit);
      @(posedge clock);
      dutRx <= 1'b0;
      repeat (bitLen) @(posedge clock);
      for (int i = 0; i < nBits; i++)
      begin
         dutRx <= bits[i];
         repeat (bitLen) @(posedge clock);
      end
      dutRx <= stopBit;
      repeat (bitLen) @(posedge clock);
      dutRx <= 1'b1;
      repeat (bitLen) @(posedge clock);
   endtask
   // ****
   // frames from the device, sampled mid bit
   // ****
   initial
   begin
      dutRx = 1'b1;
      rxValid = 1'b0;
      rxByte = 8'h00;
      forever
      begin
         @(negedge dutTx);
         repeat (bitLen / 2) @(posedge clock);
         for (int i = 0; i < 8; i++)
         begin
            repeat (bitLen) @(posedge clock);
            rxByte[i] <= dutTx;
         end
         repeat (bitLen) @(posedge clock);
         rxValid <= dutTx;
         @(posedge clock);
         rxValid <= 1'b0;
      end
   end
endmodule // serial_peer
`default_nettype wire

//--- verif/tb_async_serial_comm_interface.sv
`timescale 1ns/1ns
`default_nettype none
module tb_async_serial_comm_interface import sci_pkg::*; ;
   logic clock, rst, wrEn, rdEn, serialRxPin, serialTxPin, txIrq, rxIrq, rxValid;
   logic pend = 1'b0;
   logic [15:0] addr, wrData, rdData;
   logic [7:0] rxByte, b, fq[17];
   logic [15:0] rdQ[$], txQ[$];
   int errTotal = 0, checks = 0;
   async_serial_comm_interface #(.FIFO_DEPTH(16)) u_dut (.clock(clock), .rst(rst), .addr(addr),
      .wrEn(wrEn), .rdEn(rdEn), .wrData(wrData), .rdData(rdData), .serialRxPin(serialRxPin),
      .serialTxPin(serialTxPin), .txIrq(txIrq), .rxIrq(rxIrq));
   serial_peer u_peer (.clock(clock), .dutTx(serialTxPin), .dutRx(serialRxPin),
      .rxValid(rxValid), .rxByte(rxByte));
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // ****
   // tasks
   // ****
   task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         errTotal++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic access(input logic [15:0] a, input logic [15:0] d, input logic isRd);
      @(posedge clock);
      addr <= a;
      wrData <= d;
      wrEn <= !isRd;
      rdEn <= isRd;
      @(posedge clock);
      wrEn <= 1'b0;
      rdEn <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      access(a, d, 1'b0);
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      rdQ.push_back(exp);
      access(a, 16'h0000, 1'b1);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, errTotal);
      if (errTotal == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ****
   // result watcher
   // ****
   always @(posedge clock)
   begin
      if (pend)
         compare("read data", rdQ.pop_front(), rdData);
      if (rxValid)
         compare("serial byte", txQ.pop_front(), {8'h00, rxByte});
      pend <= rdEn;
   end
   initial
   begin
      repeat (40000) @(posedge clock);
      errTotal++;
      summarize();
   end
   initial
   begin
      rst = 1'b1;
      addr = 16'h0000;
      wrData = 16'h0000;
      wrEn = 1'b0;
      rdEn = 1'b0;
      b = 8'($urandom(32'h1d5f_2f79));
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      rd(ADDR_FORMAT, 16'h0007);
      wr(ADDR_FORMAT, 16'hab07);
      rd(ADDR_FORMAT, 16'h0007);
      rd(16'h7058, 16'h0000);
      rd(ADDR_RX_STATUS, 16'h0000);
      wr(ADDR_BAUD_HI, 16'h0012);
      rd(ADDR_BAUD_HI, 16'h0012);
      wr(ADDR_BAUD_HI, 16'h0000);
      $display("registers done");
      wr(ADDR_CTRL1, 16'h0003);
      wr(ADDR_CTRL2, 16'h0003);
      for (int d = 4; d >= 0; d -= 2)
      begin
         wr(ADDR_BAUD_LO, 16'(d));
         rd(ADDR_BAUD_LO, 16'(d));
         u_peer.bitLen = d == 0 ? 16 : 8 * (d + 1);
         b = 8'($urandom);
         txQ.push_back({8'h00, b});
         wr(ADDR_TX_BUF, {8'($urandom), b});
         repeat (3 * u_peer.bitLen) @(posedge clock);
         rd(ADDR_CTRL2, 16'h0083);
         for (int n = 0; n < 1000 && txQ.size() > 0; n++) @(posedge clock);
         compare("frames pending", 16'h0000, 16'(txQ.size()));
         repeat (2 * u_peer.bitLen) @(posedge clock);
         rd(ADDR_CTRL2, 16'h00c3);
      end
      $display("transmit done");
      b = 8'($urandom) | 8'h01;
      u_peer.sendFrame({1'b0, b}, 8, 1'b1);
      rd(ADDR_RX_STATUS, 16'h0040);
      rd(ADDR_RX_EMU, {8'h00, b});
      rd(ADDR_RX_BUF, {8'h00, b});
      rd(ADDR_RX_STATUS, 16'h0000);
      u_peer.sendFrame({1'b0, b}, 8, 1'b0);
      rd(ADDR_RX_STATUS, 16'h00d0);
      rd(ADDR_RX_BUF, {8'h00, b});
      wr(ADDR_FORMAT, 16'h0027);
      for (int k = 0; k < 2; k++)
      begin
         u_peer.sendFrame({(^b) ^ k[0], b}, 9, 1'b1);
         rd(ADDR_RX_STATUS, k ? 16'h0040 : 16'h00c4);
         rd(ADDR_RX_BUF, {8'h00, b});
      end
      $display("receive done");
      wr(ADDR_FORMAT, 16'h0007);
      wr(ADDR_FIFO_TX, 16'h0080);
      rd(ADDR_FIFO_TX, 16'h0080);
      for (int i = 0; i < 17; i++)
      begin
         fq[i] = 8'($urandom);
         u_peer.sendFrame({1'b0, fq[i]}, 8, 1'b1);
      end
      rd(ADDR_FIFO_RX, 16'h0010);
      for (int i = 0; i < 16; i++)
         rd(ADDR_RX_BUF, {8'h00, fq[i]});
      rd(ADDR_FIFO_RX, 16'h0000);
      wr(ADDR_CTRL2, 16'h0001);
      u_peer.sendFrame(9'h000, 8, 1'b0);
      rd(ADDR_RX_STATUS, 16'h00f8);
      compare("irqs", 16'h0003, 16'({txIrq, rxIrq}));
      repeat (2) @(posedge clock);
      $display("fifo done");
      summarize();
   end
endmodule // tb_async_serial_comm_interface
`default_nettype wire
